// file: design/cps_pkg.sv
// Purpose: shared constants and types for the charger protection sequencer
// Assumes: 10 MHz core clock, comparator flags arrive as asynchronous levels
// Notes: all delay windows are counted in 1 ms steps from a cycle divider
package cps_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1_000_000;
  // cycles in one millisecond, least time rounded up
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // windows in milliseconds, QUAL_MS and EVAL_MS measured from adapter detection
  localparam logic [9:0] QUAL_MS = 10'h2bc;   // 700 ms
  localparam logic [9:0] EVAL_MS = 10'h2be;   // 702 ms
  localparam logic [9:0] BLANK_MS = 10'h002;  // 2 ms after the adapter drive starts

  // register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTRL_CHG_BIT = 0;
  localparam int CTRL_LEARN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int STAT_MS_LSB = 0;
  localparam int STAT_FLAG_LSB = 10;
  localparam int STAT_STATE_LSB = 16;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_QUAL,
    SEQ_BATOFF,
    SEQ_ADAPTER,
    SEQ_LATCHED
  } cps_state_t;

  // analog comparator results, all active high
  typedef struct packed {
    logic supply_ok;               // main_supply above 5 V
    logic sense_above_06;          // adapter_sense_input above 0.6 V
    logic sense_above_24;          // adapter_sense_input above 2.4 V
    logic ovp_trip;                // overvoltage_set_input above 3.1 V
    logic cell_ov_104;             // cell_stack_node above 104 %
    logic cell_below_102;          // cell_stack_node below 102 %
    logic depleted_cell;           // depleted_cell_comparator, 2.9 V per cell
    logic charge_oc;               // charge current above 145 %
    logic thermal_hot;             // thermal_trip above 155 C
    logic thermal_cool;            // junction below 135 C
    logic input_overcurrent_limit; // input current being limited
    logic overpower_cap_2v;        // input_overpower_timer above 2 V
    logic sense_neg_low;           // input_sense_neg below 2.4 V
  } cps_cmp_t;

  typedef struct packed {
    logic input_current_monitor_en;
    logic gate_drive_regulator_en;
    logic adapter_switch_drive;
    logic battery_switch_drive;
    logic charge_en;
    logic high_side_off;
    logic cell_sink_en;
    logic precharge_sel;
    logic cap_source_en;
    logic cap_sink_en;
    logic adapter_ok_n_level;      // open-drain data, always low
    logic adapter_ok_n_en_n;       // low while the pin is pulled low
  } cps_drv_t;

  localparam cps_drv_t DRV_RESET = '{adapter_ok_n_en_n: 1'b1, default: 1'b0};

  typedef struct packed {
    cps_cmp_t s1;
    cps_cmp_t s2;
    cps_state_t state;
    logic [15:0] tick_cnt;
    logic [9:0] det_ms;
    logic [9:0] blank_ms;
    logic cell_ov;
    logic hot;
    logic learn_dep;
    logic [1:0] ctrl;
    logic [31:0] rdata;
    cps_drv_t drv;
  } cps_st_t;

endpackage

// file: design/cps_sequencer.sv
// Purpose: fault handling and power selector sequencing for a battery charger
// Assumes: comparators give clean levels; analog loops live outside this block
// Notes: one state struct, one comb copy, one register stage
//
// Summary of operation
// - input current monitor enabled only with supply above 5 V and sense above 0.6 V
// - input overvoltage: charging off, adapter switch off, battery switch on
// - input overvoltage does not latch; operation resumes when it clears
// - supply below 5 V keeps regulator, reference and gate bias off
// - stop high side above 104 % cell voltage until below 102 %
// - 10 mA cell sink on only while charging
// - depleted cell selects one-eighth pre-charge current, hysteresis restores full
// - learn with depleted cell: battery switch off, adapter switch on
// - cell recovers while learn still high: adapter off, battery back on
// - charge current above 145 % turns high side off, resumes automatically
// - thermal trip above 155 C keeps converter off until below 135 C
// - adapter ok is open-drain active low, asserted after qualification delay
// - wait 700 ms, assert adapter ok, battery off, then adapter drive on
// - input overcurrent limit flag trips at 1.5x programmed limit, 100 mV cap
// - first 2 ms of adapter drive: limiting allowed, over-power latch inhibited
// - over-power latch sets when timer capacitor exceeds 2 V
// - timer capacitor source while limiting, fixed sink otherwise
// - latch set: charging off, adapter switch off, battery switch on
// - latch clears only on adapter sense cycle or supply undervoltage cycle
// - latch conditions evaluated only 702 ms after adapter detection
// - after the 2 ms window a system short also latches off
`timescale 1ns/10ps
module cps_sequencer #(
  parameter int MS_CYCLES_P = cps_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire cps_pkg::cps_cmp_t cmp_flags,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  output cps_pkg::cps_drv_t drive
);
  import cps_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_int_n;
  cps_st_t q;
  cps_st_t d;

  // reset is released synchronously so every flop leaves reset on one edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_q[1];

  function automatic logic in_window(input logic [9:0] ms, input logic [9:0] lim);
    in_window = (ms == lim);
  endfunction

  cps_cmp_t c;
  logic uv;
  logic det;
  logic tick_hit;
  logic learn_bat;
  logic opl_trip;
  logic ad;
  logic chg;
  logic ok_assert;
  cps_drv_t nd;

  always_comb begin
    d = q;
    c = q.s2;
    nd = DRV_RESET;
    // first stage is read only by the second
    d.s1 = cmp_flags;
    d.s2 = q.s1;
    uv = ~c.supply_ok;
    det = c.sense_above_24 & ~uv;
    tick_hit = (q.tick_cnt == 16'(MS_CYCLES_P - 1));

    // register bus
    d.rdata = 32'h0000_0000;
    if (bus_wr && bus_addr == REG_CTRL) begin
      d.ctrl = bus_wdata[1:0];
    end
    if (bus_rd) begin
      case (bus_addr)
        REG_CTRL: d.rdata = {30'h0000_0000, q.ctrl};
        REG_STATUS: begin
          d.rdata[STAT_MS_LSB +: 10] = q.det_ms;
          d.rdata[STAT_FLAG_LSB +: 6] = {c.depleted_cell, q.learn_dep, q.hot, q.cell_ov, uv,
                                         q.state == SEQ_LATCHED};
          d.rdata[STAT_STATE_LSB +: 3] = q.state;
        end
        default: d.rdata = 32'h0000_0000;
      endcase
    end

    // hysteresis flags held between their two comparator thresholds
    if (c.cell_ov_104) begin
      d.cell_ov = 1'b1;
    end else if (c.cell_below_102) begin
      d.cell_ov = 1'b0;
    end
    if (c.thermal_hot) begin
      d.hot = 1'b1;
    end else if (c.thermal_cool) begin
      d.hot = 1'b0;
    end
    // comparator already has hysteresis, so recovery simply follows it
    d.learn_dep = q.ctrl[CTRL_LEARN_BIT] & c.depleted_cell;

    // millisecond divider and windows, all restart on loss of detect or supply
    if (!det) begin
      d.tick_cnt = 16'h0000;
      d.det_ms = 10'h000;
    end else begin
      d.tick_cnt = tick_hit ? 16'h0000 : q.tick_cnt + 16'h0001;
      if (tick_hit && !in_window(q.det_ms, EVAL_MS)) begin
        d.det_ms = q.det_ms + 10'h001;
      end
    end
    if (q.state != SEQ_ADAPTER || !q.drv.adapter_switch_drive) begin
      d.blank_ms = 10'h000;
    end else if (tick_hit && !in_window(q.blank_ms, BLANK_MS + 10'h001)) begin
      // ticks run on the detect grid, so one extra tick makes the window at least 2 ms
      d.blank_ms = q.blank_ms + 10'h001;
    end

    // latch only after both windows, on capacitor threshold or system short
    opl_trip = in_window(q.blank_ms, BLANK_MS + 10'h001) && in_window(q.det_ms, EVAL_MS) &&
               (c.overpower_cap_2v || c.sense_neg_low);

    if (uv) begin
      d.state = SEQ_IDLE;
    end else begin
      case (q.state)
        SEQ_IDLE: begin
          if (det) begin
            d.state = SEQ_QUAL;
          end
        end
        SEQ_QUAL: begin
          if (!det) begin
            d.state = SEQ_IDLE;
          end else if (in_window(q.det_ms, QUAL_MS)) begin
            d.state = SEQ_BATOFF;
          end
        end
        SEQ_BATOFF: begin
          // one cycle with both switches off: battery leaves before adapter joins
          d.state = det ? SEQ_ADAPTER : SEQ_IDLE;
        end
        SEQ_ADAPTER: begin
          if (!det) begin
            d.state = SEQ_IDLE;
          end else if (opl_trip) begin
            d.state = SEQ_LATCHED;
          end
        end
        SEQ_LATCHED: begin
          // only a fall of adapter sense, or undervoltage, leaves the latch
          if (!det) begin
            d.state = SEQ_IDLE;
          end
        end
        default: d.state = SEQ_IDLE;
      endcase
    end

    // outputs, registered one cycle after the synchronised flags, two after the hysteresis and learn flags
    learn_bat = q.ctrl[CTRL_LEARN_BIT] & ~q.learn_dep;
    ad = ~uv && q.state == SEQ_ADAPTER && ~c.ovp_trip && ~learn_bat;
    chg = ad & q.ctrl[CTRL_CHG_BIT] & ~q.hot;
    ok_assert = ~uv && (q.state == SEQ_BATOFF || q.state == SEQ_ADAPTER ||
                        q.state == SEQ_LATCHED);
    nd.input_current_monitor_en = c.supply_ok & c.sense_above_06;
    nd.gate_drive_regulator_en = c.supply_ok;
    nd.adapter_switch_drive = ad;
    nd.battery_switch_drive = ~uv & ~ad & ~(q.state == SEQ_BATOFF & ~c.ovp_trip);
    nd.charge_en = chg;
    nd.high_side_off = ~chg | q.cell_ov | c.charge_oc | q.hot;
    nd.cell_sink_en = chg;
    nd.precharge_sel = c.depleted_cell;
    // the limit flag is the analog trip at 1.5x with 100 mV clamp
    nd.cap_source_en = ad & c.input_overcurrent_limit;
    nd.cap_sink_en = ~(ad & c.input_overcurrent_limit);
    nd.adapter_ok_n_level = 1'b0;
    nd.adapter_ok_n_en_n = ~ok_assert;
    d.drv = nd;
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      q <= '{state: SEQ_IDLE, ctrl: CTRL_RESET, drv: DRV_RESET, default: '0};
    end else begin
      q <= d;
    end
  end

  assign drive = q.drv;
  assign bus_rdata = q.rdata;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_int_n);

  mon_enable_a: assert property (!(q.s2.supply_ok && q.s2.sense_above_06) |=> !drive.input_current_monitor_en)
    else $error("current monitor enabled without supply and sense");
  ovp_path_a: assert property (q.s2.ovp_trip && q.s2.supply_ok |=>
      !drive.adapter_switch_drive && drive.battery_switch_drive && !drive.charge_en)
    else $error("overvoltage did not select battery path");
  bias_off_a: assert property (!q.s2.supply_ok |=> !drive.gate_drive_regulator_en &&
      !drive.adapter_switch_drive && !drive.battery_switch_drive && drive.adapter_ok_n_en_n)
    else $error("undervoltage left bias or switches on");
  cell_ov_hold_a: assert property (q.cell_ov && !q.s2.cell_below_102 |=> drive.high_side_off)
    else $error("high side enabled during cell overvoltage");
  sink_charge_a: assert property (drive.cell_sink_en == drive.charge_en)
    else $error("cell sink not tied to charging");
  qual_order_a: assert property ($rose(drive.adapter_switch_drive) && $past(q.state, 2) == SEQ_BATOFF |->
      !$past(drive.battery_switch_drive) && !$past(drive.adapter_ok_n_en_n))
    else $error("adapter drive before battery off and adapter ok");
  latch_window_a: assert property ($changed(q.state) && q.state == SEQ_LATCHED |->
      $past(q.blank_ms) == BLANK_MS + 10'h001 && $past(q.det_ms) == EVAL_MS)
    else $error("latch set inside blanking window");
  latch_hold_a: assert property (q.state == SEQ_LATCHED && q.s2.sense_above_24 && q.s2.supply_ok |=>
      q.state == SEQ_LATCHED ##1 !drive.adapter_switch_drive)
    else $error("latch cleared without adapter or supply cycle");
  cap_source_a: assert property (drive.cap_source_en |-> drive.adapter_switch_drive && !drive.cap_sink_en)
    else $error("capacitor source and sink conflict");

  adapter_on_c: cover property ($rose(drive.adapter_switch_drive));
  latch_off_c: cover property ($rose(q.state == SEQ_LATCHED));
  learn_swap_c: cover property (q.ctrl[CTRL_LEARN_BIT] && $rose(q.learn_dep));
  ovp_recover_c: cover property ($fell(q.s2.ovp_trip) && q.state == SEQ_ADAPTER);

endmodule

// file: tb/cps_switch_model.sv
// Purpose: far-side model of the power switches and the adapter ok pull-up
// Assumes: drive fields are registered levels from the sequencer
// Notes: a released open-drain pin reads the pull-up, never the stale data level
`timescale 1ns/10ps
module cps_switch_model (
  input wire cps_pkg::cps_drv_t drive,
  output logic ok_pin,
  output logic sys_adapter,
  output logic sys_battery
);
  import cps_pkg::*;
  // only the enable pulls the pin down; otherwise the external pull-up wins
  assign ok_pin = drive.adapter_ok_n_en_n ? 1'b1 : drive.adapter_ok_n_level;
  assign sys_adapter = drive.adapter_switch_drive;
  assign sys_battery = drive.battery_switch_drive;
endmodule

// file: tb/tb_top.sv
// Purpose: self-checking bench for the charger protection sequencer
// Assumes: MS_CYCLES_P of 4, so one ms is four clocks
// Notes: flag changes are given six clocks to settle; every wait is bounded
`timescale 1ns/10ps
module tb_top;
  import cps_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cps_cmp_t flags = '0;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0000_0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  cps_drv_t drive;
  logic ok_pin;
  logic sys_adapter;
  logic sys_battery;
  int errors = 0;
  int comparisons = 0;
  int n;
  always #50 clk = ~clk;
  cps_sequencer #(.MS_CYCLES_P(4)) dut (.clk(clk), .rst_n(rst_n), .cmp_flags(flags), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .drive(drive));
  cps_switch_model far (.drive(drive), .ok_pin(ok_pin), .sys_adapter(sys_adapter), .sys_battery(sys_battery));
  task automatic stop_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask
  // adapter, battery, charge as one word
  function automatic logic [31:0] sw();
    return 32'({sys_adapter, sys_battery, drive.charge_en});
  endfunction
  // qualification is 700 ms of 4 clocks plus sync and sequencing slack
  task automatic wait_adp();
    n = 0;
    while (sys_adapter !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 4000) begin
        errors++;
        stop_test();
      end
    end
    chk(32'(n >= 2798 && n <= 2812), 32'h1);
    chk(32'(ok_pin), 32'h0);
    chk(sw(), 32'h5);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // internal reset still held at the first edge after release
    repeat (1) @(posedge clk);
    #1;
    chk(32'(drive), 32'(DRV_RESET));
    rd(REG_CTRL, 32'h0000_0000);
    wr(REG_CTRL, 32'hffff_ffff);
    rd(REG_CTRL, 32'h0000_0003);
    rd(8'h08, 32'h0000_0000);
    wr(REG_STATUS, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0001);
    flags.sense_above_06 <= 1'b1;
    settle();
    chk(32'(drive.input_current_monitor_en), 32'h0);
    chk(32'(drive.gate_drive_regulator_en), 32'h0);
    flags.supply_ok <= 1'b1;
    settle();
    chk(32'(drive.input_current_monitor_en), 32'h1);
    chk(32'(drive.gate_drive_regulator_en), 32'h1);
    flags.sense_above_24 <= 1'b1;
    settle();
    chk(32'(ok_pin), 32'h1);
    wait_adp();
    // inside the blanking window the over-power flag must be ignored
    flags.overpower_cap_2v <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(sw(), 32'h5);
    flags.overpower_cap_2v <= 1'b0;
    settle();
    chk(32'(drive.cell_sink_en), 32'h1);
    flags.ovp_trip <= 1'b1;
    settle();
    chk(sw(), 32'h2);
    chk(32'(drive.cell_sink_en), 32'h0);
    flags.ovp_trip <= 1'b0;
    settle();
    chk(sw(), 32'h5);
    flags.cell_ov_104 <= 1'b1;
    settle();
    chk(32'(drive.high_side_off), 32'h1);
    flags.cell_ov_104 <= 1'b0;
    settle();
    chk(32'(drive.high_side_off), 32'h1);
    flags.cell_below_102 <= 1'b1;
    settle();
    chk(32'(drive.high_side_off), 32'h0);
    flags.thermal_hot <= 1'b1;
    settle();
    chk(32'(drive.charge_en), 32'h0);
    flags.thermal_hot <= 1'b0;
    settle();
    chk(32'(drive.charge_en), 32'h0);
    flags.thermal_cool <= 1'b1;
    settle();
    chk(32'(drive.charge_en), 32'h1);
    flags.charge_oc <= 1'b1;
    settle();
    chk(32'(drive.high_side_off), 32'h1);
    flags.charge_oc <= 1'b0;
    settle();
    chk(32'(drive.high_side_off), 32'h0);
    flags.input_overcurrent_limit <= 1'b1;
    settle();
    chk(32'({drive.cap_source_en, drive.cap_sink_en}), 32'h2);
    flags.input_overcurrent_limit <= 1'b0;
    settle();
    chk(32'({drive.cap_source_en, drive.cap_sink_en}), 32'h1);
    wr(REG_CTRL, 32'h0000_0003);
    settle();
    chk(sw(), 32'h2);
    flags.depleted_cell <= 1'b1;
    settle();
    chk(32'(drive.precharge_sel), 32'h1);
    chk(sw() >> 1, 32'h2);
    flags.depleted_cell <= 1'b0;
    settle();
    chk(32'(drive.precharge_sel), 32'h0);
    chk(sw() >> 1, 32'h1);
    wr(REG_CTRL, 32'h0000_0001);
    flags.overpower_cap_2v <= 1'b1;
    // adapter drive restarts, so the blanking window runs again first
    repeat (20) @(posedge clk);
    settle();
    chk(sw(), 32'h2);
    flags.overpower_cap_2v <= 1'b0;
    settle();
    chk(sw(), 32'h2);
    flags.sense_above_24 <= 1'b0;
    settle();
    chk(32'(ok_pin), 32'h1);
    flags.sense_above_24 <= 1'b1;
    wait_adp();
    settle();
    flags.sense_neg_low <= 1'b1;
    settle();
    chk(sw(), 32'h2);
    flags.sense_neg_low <= 1'b0;
    flags.supply_ok <= 1'b0;
    settle();
    chk(sw(), 32'h0);
    chk(32'(ok_pin), 32'h1);
    chk(32'(drive.gate_drive_regulator_en), 32'h0);
    flags.supply_ok <= 1'b1;
    // a fresh qualification proves the latch was cleared by the undervoltage
    wait_adp();
    stop_test();
  end
endmodule
